// ### hw/ubg_top.sv
// Purpose: Baud-rate generator with prescaler, fractional divider, 8-bit
//          reload timer, APB registers and LIN automatic baud sync
// Assumes: MCLK 200 MHz, NRST synchronous active low, RXD asynchronous
// Notes: BAUD_PULSE is the clock pulse to the serial channel
//
// The placing of the registers and the APB interface to the registers were decided locally.
`default_nettype none

module ubg_top #(
    parameter int BRK_MIN_CYC = ubg_pkg::BRK_MIN_CYC
) (
    input wire logic MCLK,
    input wire logic NRST,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [ubg_pkg::ADDR_W-1:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    input wire logic RXD,
    output logic BAUD_PULSE,
    output logic NORMAL_DIV_PULSE,
    output logic FRAME_SYNC
);
    import ubg_pkg::*;

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic rx_m;
        logic rx_s;
        logic [6:0] pre_cnt;
        logic [7:0] baud_cnt;
        logic baud_pulse;
        logic div_pulse;
        logic frame_sync;
        logic run;
        logic [2:0] pre_exp;
        logic auto_en;
        logic [7:0] reload;
        logic fd_on;
        logic fd_mode;
        logic [7:0] step;
        logic synced;
        logic [31:0] prdata;
        logic slverr;
    } ubg_top_st_t;

    ubg_top_st_t st_r;
    ubg_top_st_t st_nxt;

    logic pre_tick;
    logic frac_tick;
    logic norm_tick;
    logic timer_clk;
    logic timer_run;
    logic underflow;
    logic lin_adopt;
    logic lin_frame;
    logic [MEAS_W-1:0] lin_meas;
    ubg_lin_state_t lin_state;
    logic setup_ph;
    logic wr_acc;
    logic [31:0] rd_val;
    logic rd_hit;

    // ------------------------------------------------------------
    // Functions
    // ------------------------------------------------------------
    function automatic logic [6:0] pre_mask(input logic [2:0] e);
        logic [7:0] m;
        m = (8'h01 << e) - 8'h01;
        return m[6:0];
    endfunction

    // Reload that reproduces a sixteenth of the measured bit time via prescaler only
    function automatic logic [7:0] calc_reload(
        input logic [MEAS_W-1:0] m,
        input logic [2:0] e
    );
        logic [MEAS_W-1:0] per;
        per = m >> (MEAS_SHIFT + int'(e));
        if (per > MEAS_W'(256)) begin
            return 8'hff;
        end
        if (per < MEAS_W'(2)) begin
            // Keep factor times reload-plus-one above one
            return (e == 3'h0) ? 8'h01 : 8'h00;
        end
        return 8'(per - MEAS_W'(1));
    endfunction

    function automatic logic addr_known(input logic [ADDR_W-1:0] a);
        return (a == OFS_BAUD_CTRL) || (a == OFS_RELOAD) ||
               (a == OFS_FRAC_CTRL) || (a == OFS_STEP) ||
               (a == OFS_SYNC_STAT) || (a == OFS_MEAS);
    endfunction

    // ------------------------------------------------------------
    // Submodules
    // ------------------------------------------------------------
    ubg_frac_div u_frac (
        .clk(MCLK),
        .rst_n(NRST),
        .tick_in(pre_tick),
        .enable(st_r.fd_on),
        .mode(st_r.fd_mode),
        .step(st_r.step),
        .frac_tick(frac_tick),
        .norm_tick(norm_tick)
    );

    ubg_lin_sync #(
        .BRK_MIN(BRK_MIN_CYC)
    ) u_lin (
        .clk(MCLK),
        .rst_n(NRST),
        .enable(st_r.auto_en),
        .rx(st_r.rx_s),
        .adopt(lin_adopt),
        .frame_start(lin_frame),
        .meas(lin_meas),
        .state(lin_state)
    );

    // ------------------------------------------------------------
    // Clock chain decode
    // ------------------------------------------------------------
    // Prescaler tick every 2^exp input clocks
    assign pre_tick = (st_r.pre_cnt >= pre_mask(st_r.pre_exp));
    assign timer_clk = st_r.fd_on ? frac_tick : pre_tick;
    // Normal divider mode freezes the timer regardless of run
    assign timer_run = st_r.run && !(st_r.fd_on && st_r.fd_mode);
    assign underflow = timer_run && timer_clk &&
                       (st_r.baud_cnt == 8'h00);

    // ------------------------------------------------------------
    // APB decode
    // ------------------------------------------------------------
    assign setup_ph = PSEL && !PENABLE;
    assign wr_acc = PSEL && PENABLE && PWRITE;
    assign PREADY = 1'b1;
    assign PRDATA = st_r.prdata;
    assign PSLVERR = st_r.slverr && PSEL && PENABLE;

    always_comb begin
        rd_val = 32'h00000000;
        rd_hit = addr_known(PADDR);
        if (PADDR == OFS_BAUD_CTRL) begin
            rd_val[BC_RUN] = st_r.run;
            rd_val[BC_PRE_HI:BC_PRE_LO] = st_r.pre_exp;
            rd_val[BC_AUTO] = st_r.auto_en;
        end else if (PADDR == OFS_RELOAD) begin
            rd_val[7:0] = st_r.reload;
        end else if (PADDR == OFS_FRAC_CTRL) begin
            rd_val[FC_ON] = st_r.fd_on;
            rd_val[FC_MODE] = st_r.fd_mode;
        end else if (PADDR == OFS_STEP) begin
            rd_val[7:0] = st_r.step;
        end else if (PADDR == OFS_SYNC_STAT) begin
            rd_val[SS_SYNCED] = st_r.synced;
            rd_val[SS_STATE_HI:SS_STATE_LO] = lin_state;
        end else if (PADDR == OFS_MEAS) begin
            rd_val[MEAS_W-1:0] = lin_meas;
        end
    end

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        st_nxt = st_r;
        st_nxt.rx_m = RXD;
        st_nxt.rx_s = st_r.rx_m;

        st_nxt.pre_cnt = pre_tick ? 7'h00 : st_r.pre_cnt + 7'h01;

        // Down counter; holds whenever not running, except when a LIN adopt loads it
        if (timer_run && timer_clk) begin
            if (st_r.baud_cnt == 8'h00) begin
                st_nxt.baud_cnt = st_r.reload;
            end else begin
                st_nxt.baud_cnt = st_r.baud_cnt - 8'h01;
            end
        end

        // Pulse at most every second clock: caps rate at clock/2
        st_nxt.baud_pulse = underflow && !st_r.baud_pulse;
        st_nxt.div_pulse = norm_tick;
        st_nxt.frame_sync = lin_frame;

        // Register reads captured in the setup phase
        if (setup_ph) begin
            st_nxt.prdata = PWRITE ? 32'h00000000 : rd_val;
            st_nxt.slverr = !rd_hit;
        end

        if (wr_acc) begin
            if (PADDR == OFS_BAUD_CTRL) begin
                st_nxt.run = PWDATA[BC_RUN];
                st_nxt.pre_exp = PWDATA[BC_PRE_HI:BC_PRE_LO];
                st_nxt.auto_en = PWDATA[BC_AUTO];
            end else if (PADDR == OFS_RELOAD) begin
                st_nxt.reload = PWDATA[7:0];
            end else if (PADDR == OFS_FRAC_CTRL) begin
                st_nxt.fd_on = PWDATA[FC_ON];
                st_nxt.fd_mode = PWDATA[FC_MODE];
            end else if (PADDR == OFS_STEP) begin
                st_nxt.step = PWDATA[7:0];
            end else if (PADDR == OFS_SYNC_STAT) begin
                if (PWDATA[SS_SYNCED]) begin
                    st_nxt.synced = 1'b0;
                end
            end
        end

        // Adopt host rate; hardware wins over a same-cycle write
        if (lin_adopt) begin
            st_nxt.reload = calc_reload(lin_meas, st_r.pre_exp);
            st_nxt.baud_cnt = calc_reload(lin_meas, st_r.pre_exp);
            st_nxt.synced = 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge MCLK) begin
        if (!NRST) begin
            st_r <= '0;
            st_r.rx_m <= 1'b1;
            st_r.rx_s <= 1'b1;
            st_r.run <= RST_BAUD_CTRL[BC_RUN];
            st_r.pre_exp <= RST_BAUD_CTRL[BC_PRE_HI:BC_PRE_LO];
            st_r.auto_en <= RST_BAUD_CTRL[BC_AUTO];
            st_r.reload <= RST_RELOAD;
            st_r.fd_on <= RST_FRAC_CTRL[FC_ON];
            st_r.fd_mode <= RST_FRAC_CTRL[FC_MODE];
            st_r.step <= RST_STEP;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign BAUD_PULSE = st_r.baud_pulse;
    assign NORMAL_DIV_PULSE = st_r.div_pulse;
    assign FRAME_SYNC = st_r.frame_sync;

endmodule

`default_nettype wire

// ### hw/ubg_pkg.sv
// Purpose: Shared constants and types of the baud generator with LIN sync
// Assumes: One clock MCLK at 200 MHz, APB register access
// Notes: Offsets are byte addresses of 32-bit words
`default_nettype none

package ubg_pkg;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam int ADDR_W = 8;
    localparam logic [7:0] OFS_BAUD_CTRL = 8'h00;
    localparam logic [7:0] OFS_RELOAD = 8'h04;
    localparam logic [7:0] OFS_FRAC_CTRL = 8'h08;
    localparam logic [7:0] OFS_STEP = 8'h0c;
    localparam logic [7:0] OFS_SYNC_STAT = 8'h10;
    localparam logic [7:0] OFS_MEAS = 8'h14;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int BC_RUN = 0;
    localparam int BC_PRE_LO = 1;
    localparam int BC_PRE_HI = 3;
    localparam int BC_AUTO = 4;
    localparam int FC_ON = 0;
    localparam int FC_MODE = 1;
    localparam int SS_SYNCED = 0;
    localparam int SS_STATE_LO = 8;
    localparam int SS_STATE_HI = 13;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [7:0] RST_BAUD_CTRL = 8'h00;
    localparam logic [7:0] RST_RELOAD = 8'h00;
    localparam logic [7:0] RST_FRAC_CTRL = 8'h00;
    localparam logic [7:0] RST_STEP = 8'h00;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_PS = 5000;
    // Thirteen bit times at the fastest LIN rate of 57.6 kBd
    localparam int BRK_MIN_NS = 225695;
    localparam int BRK_MIN_CYC =
        (BRK_MIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int BRK_CNT_W = 24;
    localparam int MEAS_W = 22;
    // Falling edges of the 0x55 synch byte, spanning eight bit times
    localparam logic [2:0] SYNC_FALL_EDGES = 3'h5;
    // Eight bits times sixteen oversampling
    localparam int MEAS_SHIFT = 7;

    typedef enum logic [5:0] {
        LS_IDLE = 6'b000001,
        LS_ARM = 6'b000010,
        LS_BREAK = 6'b000100,
        LS_SYNC = 6'b001000,
        LS_ADOPT = 6'b010000,
        LS_FRAME = 6'b100000
    } ubg_lin_state_t;

endpackage

`default_nettype wire

// ### hw/ubg_frac_div.sv
// Purpose: Fractional divider in front of the baud timer
// Assumes: tick_in is a one-cycle pulse from the prescaler
// Notes: Normal divider mode counts up from step to 0xff
`default_nettype none

module ubg_frac_div (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic tick_in,
    input wire logic enable,
    input wire logic mode,
    input wire logic [7:0] step,
    output logic frac_tick,
    output logic norm_tick
);
    import ubg_pkg::*;

    typedef struct packed {
        logic [7:0] acc;
        logic [7:0] cnt;
    } ubg_fd_st_t;

    ubg_fd_st_t st_r;
    ubg_fd_st_t st_nxt;
    logic [8:0] sum;

    always_comb begin
        st_nxt = st_r;
        sum = {1'b0, st_r.acc} + {1'b0, step};
        frac_tick = 1'b0;
        norm_tick = 1'b0;
        if (enable && tick_in) begin
            if (!mode) begin
                // Carry rate is step/256 of the input rate
                st_nxt.acc = sum[7:0];
                frac_tick = sum[8];
            end else if (st_r.cnt == 8'hff) begin
                st_nxt.cnt = step;
                norm_tick = 1'b1;
            end else begin
                st_nxt.cnt = st_r.cnt + 8'h01;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

endmodule

`default_nettype wire

// ### hw/ubg_lin_sync.sv
// Purpose: LIN header watcher measuring break and synch byte
// Assumes: rx is already synchronised to clk
// Notes: Returns to arming after every header
`default_nettype none

module ubg_lin_sync #(
    parameter int BRK_MIN = 45139
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic enable,
    input wire logic rx,
    output logic adopt,
    output logic frame_start,
    output logic [ubg_pkg::MEAS_W-1:0] meas,
    output ubg_pkg::ubg_lin_state_t state
);
    import ubg_pkg::*;

    typedef struct packed {
        ubg_lin_state_t state;
        logic [BRK_CNT_W-1:0] low_cnt;
        logic [MEAS_W-1:0] meas;
        logic [2:0] edges;
        logic prev_rx;
    } ubg_ls_st_t;

    ubg_ls_st_t st_r;
    ubg_ls_st_t st_nxt;
    logic fall;

    assign adopt = (st_r.state == LS_ADOPT);
    assign frame_start = (st_r.state == LS_FRAME);
    assign meas = st_r.meas;
    assign state = st_r.state;

    always_comb begin
        st_nxt = st_r;
        st_nxt.prev_rx = rx;
        fall = st_r.prev_rx && !rx;
        unique case (st_r.state)
            LS_IDLE: begin
                if (enable) begin
                    st_nxt.state = LS_ARM;
                end
            end
            LS_ARM: begin
                // Prepare reception and the measurement timer
                st_nxt.low_cnt = '0;
                st_nxt.edges = 3'h0;
                if (!rx) begin
                    st_nxt.state = LS_BREAK;
                end
            end
            LS_BREAK: begin
                if (!rx) begin
                    if (st_r.low_cnt != {BRK_CNT_W{1'b1}}) begin
                        st_nxt.low_cnt = st_r.low_cnt + 1'b1;
                    end
                end else if (st_r.low_cnt >= BRK_CNT_W'(BRK_MIN - 1)) begin
                    st_nxt.state = LS_SYNC;
                end else begin
                    // Too short: ordinary character, not a break
                    st_nxt.state = LS_ARM;
                end
            end
            LS_SYNC: begin
                if (st_r.edges != 3'h0) begin
                    st_nxt.meas = st_r.meas + 1'b1;
                end
                if (fall) begin
                    st_nxt.edges = st_r.edges + 3'h1;
                    if (st_r.edges == 3'h0) begin
                        st_nxt.meas = '0;
                    end
                    if (st_r.edges + 3'h1 == SYNC_FALL_EDGES) begin
                        st_nxt.state = LS_ADOPT;
                    end
                end else if (st_r.meas == {MEAS_W{1'b1}}) begin
                    st_nxt.state = LS_ARM;
                end
            end
            LS_ADOPT: begin
                st_nxt.state = LS_FRAME;
            end
            LS_FRAME: begin
                // Next header is measured afresh
                st_nxt.state = LS_ARM;
            end
        endcase
        if (!enable) begin
            st_nxt.state = LS_IDLE;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            st_r <= '{state: LS_IDLE, low_cnt: '0, meas: '0,
                      edges: 3'h0, prev_rx: 1'b1};
        end else begin
            st_r <= st_nxt;
        end
    end

endmodule

`default_nettype wire

// ### tb/ubg_top_monitor.sv
// Purpose: Port-level checker of the baud generator
// Assumes: Shadow register copies follow APB writes
// Notes: Period check only with divider and auto baud off
`default_nettype none

module ubg_top_checker #(
    parameter int BRK_MIN_CYC = 200
) (
    input wire logic MCLK,
    input wire logic NRST,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [ubg_pkg::ADDR_W-1:0] PADDR,
    input wire logic [31:0] PWDATA,
    input wire logic [31:0] PRDATA,
    input wire logic PREADY,
    input wire logic PSLVERR,
    input wire logic RXD,
    input wire logic BAUD_PULSE,
    input wire logic NORMAL_DIV_PULSE,
    input wire logic FRAME_SYNC
);
    timeunit 1ns;
    timeprecision 1ps;
    import ubg_pkg::*;
    logic wr;
    logic [4:0] ctl_r;
    logic [7:0] rl_r;
    logic [1:0] fc_r;
    logic [1:0] arm_r;
    logic [15:0] gap_r;
    logic [15:0] per;
    logic [15:0] low_r;
    logic brk_r;
    assign wr = PSEL && PENABLE && PWRITE && PREADY;
    assign per = (rl_r == 8'h00 && ctl_r[3:1] == 3'h0) ? 16'h0002
        : ({8'h00, rl_r} + 16'h0001) << ctl_r[3:1];

    // ------------------------------------------------------------
    // Shadow registers, pulse gap, break length
    // ------------------------------------------------------------
    always_ff @(posedge MCLK) begin
        if (!NRST) begin
            ctl_r <= 5'h00;
            rl_r <= 8'h00;
            fc_r <= 2'h0;
            arm_r <= 2'h0;
            gap_r <= 16'h0000;
            low_r <= 16'h0000;
            brk_r <= 1'b0;
        end else begin
            if (wr && PADDR == OFS_BAUD_CTRL) ctl_r <= PWDATA[4:0];
            if (wr && PADDR == OFS_RELOAD) rl_r <= PWDATA[7:0];
            if (wr && PADDR == OFS_FRAC_CTRL) fc_r <= PWDATA[1:0];
            gap_r <= BAUD_PULSE ? 16'h0001 : gap_r + 16'h0001;
            if (wr && PADDR <= OFS_FRAC_CTRL) arm_r <= 2'h0;
            else if (BAUD_PULSE && arm_r != 2'h2) arm_r <= arm_r + 2'h1;
            low_r <= RXD ? 16'h0000 : low_r + 16'h0001;
            if (FRAME_SYNC) brk_r <= 1'b0;
            else if (!RXD && 32'(low_r) >= BRK_MIN_CYC - 2) brk_r <= 1'b1;
        end
    end

    default clocking cb @(posedge MCLK); endclocking
    default disable iff (!NRST);

    property p_rate_cap;
        BAUD_PULSE |=> !BAUD_PULSE;
    endproperty
    a_rate_cap: assert property (p_rate_cap)
        else $error("baud pulses in adjacent cycles");
    property p_norm_stop;
        (fc_r == 2'h3 && $past(fc_r) == 2'h3) |-> !BAUD_PULSE;
    endproperty
    a_norm_stop: assert property (p_norm_stop)
        else $error("baud pulse in normal divider mode");
    property p_run_off;
        (!ctl_r[0] && !$past(ctl_r[0])) |-> !BAUD_PULSE;
    endproperty
    a_run_off: assert property (p_run_off)
        else $error("baud pulse with run bit clear");
    property p_period;
        (BAUD_PULSE && arm_r == 2'h2 && !fc_r[0] && !ctl_r[4])
            |-> gap_r == per;
    endproperty
    a_period: assert property (p_period)
        else $error("baud pulse period wrong");
    property p_err;
        (PSEL && PENABLE) |-> (PSLVERR == (PADDR > OFS_MEAS));
    endproperty
    a_err: assert property (p_err)
        else $error("slave error does not match address");
    property p_fs_single;
        FRAME_SYNC |=> !FRAME_SYNC [*8];
    endproperty
    a_fs_single: assert property (p_fs_single)
        else $error("frame sync longer than one cycle");
    property p_fs_auto;
        FRAME_SYNC |-> ctl_r[4];
    endproperty
    a_fs_auto: assert property (p_fs_auto)
        else $error("frame sync with auto baud off");
    property p_fs_break;
        FRAME_SYNC |-> brk_r;
    endproperty
    a_fs_break: assert property (p_fs_break)
        else $error("frame sync without a fresh break");

    c_cap: cover property (BAUD_PULSE && per == 16'h0002 && arm_r == 2'h2);
    c_frame: cover property (FRAME_SYNC);
    c_err: cover property (PSLVERR);
    c_norm: cover property (NORMAL_DIV_PULSE);
endmodule

bind ubg_top ubg_top_checker #(.BRK_MIN_CYC(BRK_MIN_CYC)) ubg_top_checker_i (
    .MCLK(MCLK), .NRST(NRST), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
    .PREADY(PREADY), .PSLVERR(PSLVERR), .RXD(RXD),
    .BAUD_PULSE(BAUD_PULSE), .NORMAL_DIV_PULSE(NORMAL_DIV_PULSE),
    .FRAME_SYNC(FRAME_SYNC)
);

`default_nettype wire

// ### tb/ubg_lin_master.sv
// Purpose: LIN master sending break, synch and identifier
// Assumes: Called right after a rising clock edge
// Notes: Line idles recessive high, as with the bus pull-up
`default_nettype none

module ubg_lin_master (
    input wire logic clk,
    output logic rxd
);
    timeunit 1ns;
    timeprecision 1ps;
    initial rxd = 1'b1;

    task automatic level(input logic v, input int n);
        rxd <= v;
        repeat (n) @(posedge clk);
    endtask

    task automatic char(input logic [7:0] b, input int bt);
        level(1'b0, bt);
        for (int i = 0; i < 8; i++) level(b[i], bt);
        level(1'b1, bt);
    endtask

    // Break, delimiter, synch byte, identifier
    task automatic send(input int bt, input int brk, input logic [7:0] id);
        level(1'b0, brk * bt);
        level(1'b1, bt);
        char(8'h55, bt);
        char(id, bt);
    endtask
endmodule

`default_nettype wire

// ### tb/ubg_top_tb.sv
// Purpose: Self-checking bench of the baud generator
// Assumes: Short break minimum for simulation
// Notes: Random values from a fixed-seed LFSR
`default_nettype none

module ubg_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import ubg_pkg::*;
    localparam int BRK = 200;
    logic MCLK, NRST, PSEL, PENABLE, PWRITE, RXD, e;
    logic [ADDR_W-1:0] PADDR;
    logic [31:0] PWDATA, PRDATA, seed, q;
    logic PREADY, PSLVERR, BAUD_PULSE, NORMAL_DIV_PULSE, FRAME_SYNC;
    logic [31:0] msk [4] = '{32'h1f, 32'hff, 32'h3, 32'hff};
    int bad_count = 0, comparisons = 0, cyc = 0, lastp = 0, gap = 0;
    int npul = 0, nnorm = 0, nfs = 0, ex, rl, bt, fs;

    initial begin
        MCLK = 1'b0;
        forever #2.5 MCLK = ~MCLK;
    end

    ubg_top #(.BRK_MIN_CYC(BRK)) ubg_top_i (
        .MCLK(MCLK), .NRST(NRST), .PSEL(PSEL), .PENABLE(PENABLE),
        .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
        .PREADY(PREADY), .PSLVERR(PSLVERR), .RXD(RXD),
        .BAUD_PULSE(BAUD_PULSE), .NORMAL_DIV_PULSE(NORMAL_DIV_PULSE),
        .FRAME_SYNC(FRAME_SYNC)
    );
    ubg_lin_master ubg_lin_master_i (.clk(MCLK), .rxd(RXD));

    always @(negedge MCLK) begin
        cyc++;
        if (BAUD_PULSE === 1'b1) begin
            npul++;
            gap = cyc - lastp;
            lastp = cyc;
        end
        if (NORMAL_DIV_PULSE === 1'b1) nnorm++;
        if (FRAME_SYNC === 1'b1) nfs++;
    end

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {1'b0, s[31:1]} ^ (s[0] ? 32'h80200003 : 32'h0);
    endfunction
    function automatic int period(input int x, input int r);
        return (x == 0 && r == 0) ? 2 : (r + 1) << x;
    endfunction
    function automatic logic [31:0] adopt(input int b);
        int r;
        r = ((8 * b) >> 7) - 1;
        if (r < 1) r = 1;
        if (r > 255) r = 255;
        return 32'(r);
    endfunction

    task automatic chk(input logic [31:0] got, input logic [31:0] want);
        comparisons++;
        if (got !== want) begin
            bad_count++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, want);
        end
    endtask
    // Setup, then access until ready; released after that edge
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge MCLK);
        PSEL <= 1'b1;
        PWRITE <= w;
        PADDR <= a;
        PWDATA <= d;
        @(posedge MCLK);
        PENABLE <= 1'b1;
        // Ends on the first edge with PREADY high; the watchdog covers a stuck wait
        do begin
            @(posedge MCLK);
        end while (PREADY !== 1'b1);
        q = PRDATA;
        e = PSLVERR;
        PSEL <= 1'b0;
        PENABLE <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] want);
        apb(1'b0, a, 32'h0);
        chk(q, want);
    endtask
    task automatic test_done;
        $display("counts: %0d mismatches, %0d compares", bad_count,
                 comparisons);
        if (bad_count == 0 && comparisons > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge MCLK);
    endtask

    initial begin
        #300000;
        bad_count++;
        test_done;
    end

    initial begin
        NRST = 1'b0;
        PSEL = 1'b0;
        PENABLE = 1'b0;
        PWRITE = 1'b0;
        PADDR = 8'h00;
        PWDATA = 32'h0;
        seed = 32'h81dc1930;
        idle(16);
        NRST <= 1'b1;
        // Status shows the idle watcher state after reset
        for (int a = 0; a < 24; a += 4) begin
            rd(8'(a), (8'(a) == OFS_SYNC_STAT) ?
                32'(LS_IDLE) << SS_STATE_LO : 32'h0);
        end
        wr(8'h18, 32'hffffffff);
        chk({31'h0, e}, 32'h1);
        rd(8'h18, 32'h0);
        chk({31'h0, e}, 32'h1);
        for (int i = 0; i < 4; i++) begin
            seed = lfsr(seed);
            wr(8'(4 * i), seed);
            rd(8'(4 * i), seed & msk[i]);
        end
        $display("test registers ended");
        // Periods: cap corner, small reload, random settings
        wr(OFS_FRAC_CTRL, 32'h0);
        for (int i = 0; i < 6; i++) begin
            seed = lfsr(seed);
            ex = (i < 2) ? 0 : int'(seed[1:0]);
            rl = (i == 0) ? 0 : (i == 1) ? 2 : int'(seed[13:8]);
            wr(OFS_RELOAD, 32'(rl));
            wr(OFS_BAUD_CTRL, 32'(1 + 2 * ex));
            idle(3 * period(ex, rl) + 600);
            chk(32'(gap), 32'(period(ex, rl)));
        end
        wr(OFS_BAUD_CTRL, 32'h0);
        idle(2);
        npul = 0;
        idle(300);
        chk(32'(npul), 32'h0);
        wr(OFS_STEP, 32'h80);
        wr(OFS_FRAC_CTRL, 32'h3);
        wr(OFS_BAUD_CTRL, 32'h1);
        idle(2);
        npul = 0;
        nnorm = 0;
        idle(300);
        chk(32'(npul), 32'h0);
        chk({31'h0, nnorm != 0}, 32'h1);
        wr(OFS_RELOAD, 32'h3);
        wr(OFS_FRAC_CTRL, 32'h1);
        // Held count may take up to 128 cycles to run out
        idle(200);
        npul = 0;
        idle(800);
        chk({31'h0, npul >= 99 && npul <= 101}, 32'h1);
        $display("test timer ended");
        // LIN headers at random bit times, each measured afresh
        wr(OFS_FRAC_CTRL, 32'h0);
        wr(OFS_BAUD_CTRL, 32'h11);
        for (int i = 0; i < 3; i++) begin
            seed = lfsr(seed);
            bt = 16 + int'(seed[5:0]);
            fs = nfs;
            ubg_lin_master_i.send(bt, 13 + int'(seed[7:6]),
                seed[15:8] | 8'h55);
            idle(4 * bt);
            chk(32'(nfs - fs), 32'h1);
            rd(OFS_RELOAD, adopt(bt));
            rd(OFS_MEAS, 32'(8 * bt));
            rd(OFS_SYNC_STAT, 32'h201);
            wr(OFS_SYNC_STAT, 32'h1);
            rd(OFS_SYNC_STAT, 32'h200);
        end
        rd(OFS_STEP, 32'h80);
        fs = nfs;
        ubg_lin_master_i.send(32, 5, 8'h55);
        idle(100);
        chk(32'(nfs - fs), 32'h0);
        $display("test lin ended");
        test_done;
    end
endmodule

`default_nettype wire
